// file: design/echo_cfg.sv
`timescale 1ns/1ps
`default_nettype none
module echo_cfg (
  input  wire logic                 mclk,
  input  wire logic                 nrst,
  input  wire logic                 cen,
  // APB slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic                      pready,
  output logic [31:0]               prdata,
  output logic                      pslverr,
  // Measurement sequencer
  input  wire logic                 meas_start,
  input  wire logic                 meas_end,
  input  wire logic                 indirect,
  input  wire logic [15:0]          measured_ringdown_period,
  input  wire logic                 ringdown_valid,
  input  wire logic [15:0]          noise_level,
  input  wire echo_cfg_pkg::echo_t  echo_in,
  input  wire logic                 tof_valid,
  input  wire logic [15:0]          tof_raw,
  output echo_cfg_pkg::cfg_t        cfg,
  output logic [15:0]               tx_period,
  output logic [15:0]               rx_period,
  output logic                      gain_ramp_on,
  output logic                      ringdown_watch,
  output logic                      log_strobe,
  output echo_cfg_pkg::echo_t       echo_out,
  output logic [15:0]               flight_time,
  output logic                      flight_time_valid
);
  logic [15:0]  programmed_tone_period;   // Auto mode period
  logic [15:0]  transmit_tone_period;     // Manual transmit period
  logic [15:0]  receive_tone_period;      // Manual receive period
  localparam int unsigned USER_BITS_W = 32;
  logic [USER_BITS_W-1:0] user_ff [echo_cfg_pkg::USER_WORDS]; // User store
  logic         first_ff;                 // Next shot uses programmed period
  logic         tol_ok_ff;                // Last ringdown period within tolerance
  logic [15:0]  meas_period_ff;           // Last ringdown period
  logic         running_ff;               // Measurement in progress
  logic [15:0]  steps;                    // 25.6 us steps since start
  logic [15:0]  log_next_ff;              // Next logging step
  logic         wr_en;                    // APB write strobe
  logic         rd_en;                    // APB read strobe

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;

  // Tolerance decode, in parts per ten thousand
  function automatic logic [15:0] tol_ppt(input logic [1:0] code);
    unique case (code)
      2'd0: tol_ppt = echo_cfg_pkg::TOL_C0;
      2'd1: tol_ppt = echo_cfg_pkg::TOL_C1;
      2'd2: tol_ppt = echo_cfg_pkg::TOL_C2;
      2'd3: tol_ppt = echo_cfg_pkg::TOL_C3;
    endcase
  endfunction

  // Step size of the logging grid, in 25.6 us units
  function automatic logic [15:0] log_incr(input logic [1:0] code);
    log_incr = 16'h0001 << code;
  endfunction

  // Step timer
  echo_timer #(.STEP(echo_cfg_pkg::STEP_CYC)) u_timer (
    .mclk  (mclk),
    .nrst  (nrst),
    .cen   (cen),
    .start (meas_start),
    .run   (running_ff),
    .steps (steps)
  );

  // Configuration fields written over APB
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cfg.gain_ramp_start_delay      <= echo_cfg_pkg::RST_GAIN_START;
      cfg.gain_ramp_filter_bandwidth <= echo_cfg_pkg::RST_GAIN_BW;
      cfg.ringdown_watch_duration    <= echo_cfg_pkg::RST_RING_DUR;
      cfg.transmit_current_trim      <= echo_cfg_pkg::RST_TRANSMIT_CURRENT_TRIM;
      cfg.ringdown_period_tolerance  <= echo_cfg_pkg::RST_TOL;
      cfg.magnitude_log_start        <= echo_cfg_pkg::RST_LOG_START;
      cfg.magnitude_log_step         <= echo_cfg_pkg::RST_LOG_STEP;
      cfg.auto_tone_period_enable    <= 1'b0;
      cfg.background_suppress_enable <= 1'b0;
      cfg.flight_time_offset         <= echo_cfg_pkg::RST_OFFSET;
      programmed_tone_period         <= echo_cfg_pkg::RST_PERIOD;
      transmit_tone_period           <= echo_cfg_pkg::RST_PERIOD;
      receive_tone_period            <= echo_cfg_pkg::RST_PERIOD;
    end else if (cen && wr_en) begin
      unique case (paddr)
        echo_cfg_pkg::OFS_GAIN: begin
          cfg.gain_ramp_start_delay      <= pwdata[3:0];
          cfg.gain_ramp_filter_bandwidth <= pwdata[echo_cfg_pkg::POS_GAIN_BW +: 2];
        end
        echo_cfg_pkg::OFS_RING: begin
          cfg.ringdown_watch_duration   <= pwdata[7:0];
          cfg.transmit_current_trim     <= pwdata[echo_cfg_pkg::POS_TRANSMIT_CURRENT_TRIM +: 6];
          cfg.ringdown_period_tolerance <= pwdata[echo_cfg_pkg::POS_TOL +: 2];
        end
        echo_cfg_pkg::OFS_LOG: begin
          cfg.magnitude_log_start <= pwdata[11:0];
          cfg.magnitude_log_step  <= pwdata[echo_cfg_pkg::POS_LOG_STEP +: 2];
        end
        echo_cfg_pkg::OFS_TONE: begin
          transmit_tone_period <= pwdata[15:0];
          receive_tone_period  <= pwdata[echo_cfg_pkg::POS_RX_PER +: 16];
        end
        echo_cfg_pkg::OFS_MEAS: begin
          cfg.auto_tone_period_enable    <= pwdata[echo_cfg_pkg::POS_AUTO];
          cfg.background_suppress_enable <= pwdata[echo_cfg_pkg::POS_SUPP];
          cfg.flight_time_offset         <= pwdata[echo_cfg_pkg::POS_OFFSET +: 6];
          programmed_tone_period         <= pwdata[echo_cfg_pkg::POS_RX_PER +: 16];
        end
        default: begin
        end
      endcase
    end
  end

  // User store words; stored only, no internal consumer
  for (genvar i = 0; i < echo_cfg_pkg::USER_WORDS; i++) begin : g_user
    always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
        user_ff[i] <= 32'h0000_0000;
      end else if (cen && wr_en && paddr == 8'(echo_cfg_pkg::OFS_USER0 + 4 * i)) begin
        if (i == echo_cfg_pkg::USER_WORDS - 1) begin
          user_ff[i] <= {8'h00, pwdata[23:0]};
        end else begin
          user_ff[i] <= pwdata;
        end
      end
    end
  end

  // APB answer: one access cycle, zero wait states
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (cen) begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        unique case (paddr)
          echo_cfg_pkg::OFS_GAIN:
            prdata <= {26'h0, cfg.gain_ramp_filter_bandwidth, cfg.gain_ramp_start_delay};
          echo_cfg_pkg::OFS_RING:
            prdata <= {14'h0, cfg.ringdown_period_tolerance, 2'h0,
                       cfg.transmit_current_trim, cfg.ringdown_watch_duration};
          echo_cfg_pkg::OFS_LOG:
            prdata <= {18'h0, cfg.magnitude_log_step, cfg.magnitude_log_start};
          echo_cfg_pkg::OFS_TONE:
            prdata <= {receive_tone_period, transmit_tone_period};
          echo_cfg_pkg::OFS_MEAS:
            prdata <= {programmed_tone_period, 2'h0, cfg.flight_time_offset, 6'h0,
                       cfg.background_suppress_enable, cfg.auto_tone_period_enable};
          echo_cfg_pkg::OFS_RESULT:
            prdata <= {16'h0, flight_time};
          echo_cfg_pkg::OFS_STAT:
            prdata <= {meas_period_ff, 13'h0, tol_ok_ff, first_ff, running_ff};
          8'h20, 8'h24, 8'h28, 8'h2c:
            prdata <= user_ff[paddr[3:2]];
          default:
            pslverr <= 1'b1;
        endcase
      end else if (psel && !penable) begin
        pslverr <= !(paddr inside {echo_cfg_pkg::OFS_GAIN, echo_cfg_pkg::OFS_RING,
                     echo_cfg_pkg::OFS_LOG, echo_cfg_pkg::OFS_TONE, echo_cfg_pkg::OFS_MEAS,
                     8'h20, 8'h24, 8'h28, 8'h2c});
      end
    end
  end

  // Auto period selection bookkeeping
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      first_ff       <= 1'b1;
      tol_ok_ff      <= 1'b0;
      meas_period_ff <= 16'h0000;
    end else if (cen) begin
      if (cen && wr_en && paddr == echo_cfg_pkg::OFS_MEAS &&
          pwdata[echo_cfg_pkg::POS_RX_PER +: 16] != programmed_tone_period) begin
        first_ff <= 1'b1;
      end else if (meas_end) begin
        first_ff <= 1'b0;
      end
      if (ringdown_valid) begin
        meas_period_ff <= measured_ringdown_period;
        // |m - p| * 10000 < p * tol, as 32-bit products
        tol_ok_ff <= (32'(measured_ringdown_period > programmed_tone_period ?
                          measured_ringdown_period - programmed_tone_period :
                          programmed_tone_period - measured_ringdown_period)
                      * 32'(echo_cfg_pkg::TOL_DEN))
                     < (32'(programmed_tone_period)
                        * 32'(tol_ppt(cfg.ringdown_period_tolerance)));
      end
    end
  end

  // Period outputs
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      tx_period <= 16'h0000;
      rx_period <= 16'h0000;
    end else if (cen) begin
      if (cfg.auto_tone_period_enable) begin
        tx_period <= (first_ff || !tol_ok_ff) ? programmed_tone_period
                                              : meas_period_ff;
        rx_period <= (indirect || first_ff || !tol_ok_ff) ? programmed_tone_period
                                                          : meas_period_ff;
      end else begin
        tx_period <= transmit_tone_period;
        rx_period <= receive_tone_period;
      end
    end
  end

  // Measurement windows
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      running_ff     <= 1'b0;
      gain_ramp_on   <= 1'b0;
      ringdown_watch <= 1'b0;
      log_strobe     <= 1'b0;
      log_next_ff    <= 16'h0000;
    end else if (cen) begin
      log_strobe <= 1'b0;
      if (meas_start) begin
        running_ff     <= 1'b1;
        gain_ramp_on   <= 1'b0;
        ringdown_watch <= 1'b1;
        log_next_ff    <= {4'h0, cfg.magnitude_log_start};
      end else if (meas_end) begin
        running_ff     <= 1'b0;
        gain_ramp_on   <= 1'b0;
        ringdown_watch <= 1'b0;
      end else if (running_ff) begin
        gain_ramp_on   <= steps >= {9'h0, cfg.gain_ramp_start_delay, 3'h0};
        ringdown_watch <= steps < {8'h0, cfg.ringdown_watch_duration};
        if (steps == log_next_ff) begin
          log_strobe  <= 1'b1;
          log_next_ff <= log_next_ff + log_incr(cfg.magnitude_log_step);
        end
      end
    end
  end

  // Echo magnitude with optional noise suppression
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      echo_out <= '0;
    end else if (cen) begin
      echo_out.valid <= echo_in.valid;
      echo_out.mag   <= (cfg.background_suppress_enable && echo_in.mag < noise_level) ?
                        16'h0000 : echo_in.mag;
    end
  end

  // Flight time less calibration offset, clamped at zero
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      flight_time       <= 16'h0000;
      flight_time_valid <= 1'b0;
    end else if (cen) begin
      flight_time_valid <= tof_valid;
      if (tof_valid) begin
        flight_time <= (tof_raw > {10'h0, cfg.flight_time_offset}) ?
                       tof_raw - {10'h0, cfg.flight_time_offset} : 16'h0000;
      end
    end
  end

  // Assertions
  gain_delay_a: assert property (@(posedge mclk) disable iff (!nrst)
    cen && running_ff && !meas_start && !meas_end &&
    steps < {9'h0, cfg.gain_ramp_start_delay, 3'h0} |=> !gain_ramp_on)
    else $error("gain ramp started early");
  tof_clamp_a: assert property (@(posedge mclk) disable iff (!nrst)
    cen && tof_valid && tof_raw <= {10'h0, cfg.flight_time_offset} |=> flight_time == 16'h0000)
    else $error("flight time not clamped");
  tof_sub_a: assert property (@(posedge mclk) disable iff (!nrst)
    cen && tof_valid && tof_raw > {10'h0, cfg.flight_time_offset}
    |=> flight_time == $past(tof_raw) - {10'h0, $past(cfg.flight_time_offset)})
    else $error("flight time offset wrong");
  noise_supp_a: assert property (@(posedge mclk) disable iff (!nrst)
    cen && cfg.background_suppress_enable && echo_in.mag < noise_level |=> echo_out.mag == 16'h0)
    else $error("noise not suppressed");
  manual_tone_a: assert property (@(posedge mclk) disable iff (!nrst)
    cen && !cfg.auto_tone_period_enable |=> tx_period == $past(transmit_tone_period))
    else $error("manual tx period wrong");
  indirect_rx_a: assert property (@(posedge mclk) disable iff (!nrst)
    cen && cfg.auto_tone_period_enable && indirect |=> rx_period == $past(programmed_tone_period))
    else $error("indirect rx period wrong");
  first_tone_a: assert property (@(posedge mclk) disable iff (!nrst)
    cen && cfg.auto_tone_period_enable && first_ff |=> tx_period == $past(programmed_tone_period))
    else $error("first shot period wrong");
  watch_win_a: assert property (@(posedge mclk) disable iff (!nrst)
    cen && running_ff && !meas_start && !meas_end &&
    steps >= {8'h0, cfg.ringdown_watch_duration} |=> !ringdown_watch)
    else $error("ringdown window too long");
  step_reset_a: assert property (@(posedge mclk) $rose(nrst) |-> cfg.magnitude_log_step == 2'h1)
    else $error("log step reset wrong");
endmodule
`default_nettype wire

// file: design/echo_cfg_pkg.sv
package echo_cfg_pkg;

  // Clock figures
  localparam int unsigned CLK_HZ           = 10_000_000;
  localparam real         STEP_US          = 25.6;
  localparam real         GAIN_STEP_US     = 204.8;
  // Cycles per 25.6 us step, rounded down (shortest time), with no lower limit
  localparam int unsigned STEP_CYC         = int'($floor(STEP_US * 10.0));
  localparam int unsigned GAIN_STEP_CYC    = int'($floor(GAIN_STEP_US * 10.0));

  // Register byte offsets
  localparam logic [7:0] OFS_GAIN   = 8'h00;
  localparam logic [7:0] OFS_RING   = 8'h04;
  localparam logic [7:0] OFS_LOG    = 8'h08;
  localparam logic [7:0] OFS_TONE   = 8'h0c;
  localparam logic [7:0] OFS_MEAS   = 8'h10;
  localparam logic [7:0] OFS_RESULT = 8'h14;
  localparam logic [7:0] OFS_STAT   = 8'h18;
  localparam logic [7:0] OFS_USER0  = 8'h20;
  localparam int unsigned USER_WORDS = 4;
  localparam int unsigned USER_BITS  = 120;

  // Field positions
  localparam int unsigned POS_GAIN_BW    = 4;
  localparam int unsigned POS_TRANSMIT_CURRENT_TRIM    = 8;
  localparam int unsigned POS_TOL        = 16;
  localparam int unsigned POS_LOG_STEP   = 12;
  localparam int unsigned POS_AUTO       = 0;
  localparam int unsigned POS_SUPP       = 1;
  localparam int unsigned POS_OFFSET     = 8;
  localparam int unsigned POS_RX_PER     = 16;

  // Reset values
  localparam logic [3:0]  RST_GAIN_START = 4'h0;
  localparam logic [1:0]  RST_GAIN_BW    = 2'h0;
  localparam logic [11:0] RST_LOG_START  = 12'h000;
  localparam logic [1:0]  RST_LOG_STEP   = 2'h1;
  localparam logic [7:0]  RST_RING_DUR   = 8'h00;
  localparam logic [5:0]  RST_TRANSMIT_CURRENT_TRIM    = 6'h00;
  localparam logic [1:0]  RST_TOL        = 2'h0;
  localparam logic [5:0]  RST_OFFSET     = 6'h00;
  localparam logic [15:0] RST_PERIOD     = 16'h0000;

  // Tolerance in units of 1/10000 of the period
  localparam logic [15:0] TOL_C0 = 16'd234;
  localparam logic [15:0] TOL_C1 = 16'd540;
  localparam logic [15:0] TOL_C2 = 16'd820;
  localparam logic [15:0] TOL_C3 = 16'd1250;
  localparam logic [15:0] TOL_DEN = 16'd10000;

  // Settings as seen by the sequencer
  typedef struct packed {
    logic [3:0]  gain_ramp_start_delay;
    logic [1:0]  gain_ramp_filter_bandwidth;
    logic [7:0]  ringdown_watch_duration;
    logic [5:0]  transmit_current_trim;
    logic [1:0]  ringdown_period_tolerance;
    logic [11:0] magnitude_log_start;
    logic [1:0]  magnitude_log_step;
    logic        auto_tone_period_enable;
    logic        background_suppress_enable;
    logic [5:0]  flight_time_offset;
  } cfg_t;

  // Echo sample from the receive chain
  typedef struct packed {
    logic        valid;
    logic [15:0] mag;
  } echo_t;

endpackage

// file: design/echo_timer.sv
`timescale 1ns/1ps
`default_nettype none
// Counts elapsed 25.6 us ticks since a measurement start
module echo_timer #(
  parameter int unsigned STEP = echo_cfg_pkg::STEP_CYC
) (
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic        cen,
  input  wire logic        start,
  input  wire logic        run,
  output logic      [15:0] steps
);
  logic [15:0] pre_ff; // Cycle prescaler

  // Prescaler and step counter restart on start
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pre_ff <= 16'h0000;
      steps  <= 16'h0000;
    end else if (cen) begin
      if (start) begin
        pre_ff <= 16'h0000;
        steps  <= 16'h0000;
      end else if (run) begin
        if (pre_ff == 16'(STEP - 1)) begin
          pre_ff <= 16'h0000;
          if (steps != 16'hffff) begin
            steps <= steps + 16'h0001;
          end
        end else begin
          pre_ff <= pre_ff + 16'h0001;
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: test/echo_front_model.sv
`timescale 1ns/1ps
`default_nettype none
// Sequencer and receive chain that feed the block during a measurement
module echo_front_model (
  input  wire logic           mclk,
  output logic                meas_start,
  output logic                meas_end,
  output logic                indirect,
  output logic [15:0]         measured_ringdown_period,
  output logic                ringdown_valid,
  output logic [15:0]         noise_level,
  output echo_cfg_pkg::echo_t echo_in,
  output logic                tof_valid,
  output logic [15:0]         tof_raw
);
  // Idle levels at time zero
  initial begin
    meas_start = 1'b0;
    meas_end = 1'b0;
    indirect = 1'b0;
    measured_ringdown_period = 16'h0000;
    ringdown_valid = 1'b0;
    noise_level = 16'h0000;
    echo_in = '0;
    tof_valid = 1'b0;
    tof_raw = 16'h0000;
  end
  // One-cycle start pulse, direct or indirect
  task automatic open_meas(input logic ind);
    @(posedge mclk);
    meas_start <= 1'b1;
    indirect <= ind;
    @(posedge mclk);
    meas_start <= 1'b0;
  endtask
  // Ringdown period report, then the end pulse
  task automatic close_meas(input logic [15:0] per);
    @(posedge mclk);
    measured_ringdown_period <= per;
    ringdown_valid <= 1'b1;
    @(posedge mclk);
    ringdown_valid <= 1'b0;
    measured_ringdown_period <= ~per;  // Stale data is not held
    meas_end <= 1'b1;
    @(posedge mclk);
    meas_end <= 1'b0;
    indirect <= 1'b0;
  endtask
  // One echo sample against a background level
  task automatic send_echo(input logic [15:0] mag, input logic [15:0] noise);
    @(posedge mclk);
    noise_level <= noise;
    echo_in <= {1'b1, mag};
    @(posedge mclk);
    echo_in <= {1'b0, ~mag};
  endtask
  // One raw flight time report
  task automatic send_tof(input logic [15:0] raw);
    @(posedge mclk);
    tof_raw <= raw;
    tof_valid <= 1'b1;
    @(posedge mclk);
    tof_valid <= 1'b0;
    tof_raw <= ~raw;
  endtask
endmodule
`default_nettype wire

// file: test/echo_measurement_config_tb.sv
`timescale 1ns/1ps
`default_nettype none
// Register and measurement checks for the echo configuration block
module echo_measurement_config_tb;
  logic mclk, nrst, cen, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic meas_start, meas_end, indirect, ringdown_valid, tof_valid, err;
  logic [15:0] measured_ringdown_period, noise_level, tof_raw;
  logic [15:0] tx_period, rx_period, flight_time;
  logic gain_ramp_on, ringdown_watch, log_strobe, flight_time_valid;
  echo_cfg_pkg::echo_t echo_in, echo_out;
  echo_cfg_pkg::cfg_t  cfg;
  int mismatches, n_tests, cnt;
  localparam logic [15:0] P1 = 16'd1000;
  // Offsets just inside and just outside each tolerance band
  logic [15:0] dev [8] = '{16'd23, 16'd24, 16'd53, 16'd54, 16'd81, 16'd82, 16'd124, 16'd125};

  echo_cfg dut_u (.mclk(mclk), .nrst(nrst), .cen(cen), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .meas_start(meas_start), .meas_end(meas_end), .indirect(indirect),
    .measured_ringdown_period(measured_ringdown_period), .ringdown_valid(ringdown_valid),
    .noise_level(noise_level), .echo_in(echo_in), .tof_valid(tof_valid), .tof_raw(tof_raw),
    .cfg(cfg), .tx_period(tx_period), .rx_period(rx_period), .gain_ramp_on(gain_ramp_on),
    .ringdown_watch(ringdown_watch), .log_strobe(log_strobe), .echo_out(echo_out),
    .flight_time(flight_time), .flight_time_valid(flight_time_valid));
  echo_front_model fm_u (.mclk(mclk), .meas_start(meas_start), .meas_end(meas_end),
    .indirect(indirect), .measured_ringdown_period(measured_ringdown_period),
    .ringdown_valid(ringdown_valid), .noise_level(noise_level), .echo_in(echo_in),
    .tof_valid(tof_valid), .tof_raw(tof_raw));

  // 10 MHz clock
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // Counted comparison
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int g;
    g = 0;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1 && g < 50) begin
      g++;
      @(posedge mclk);
    end
    // A bus that never answers counts against the run
    if (g >= 50) begin
      mismatches++;
      $display("Error at %0t: no bus answer", $time);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Read and compare
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  // Measurement that checks the transmit period it started with
  task automatic meas_tx(input logic [15:0] feed, input logic [15:0] exp);
    fm_u.open_meas(1'b0);
    repeat (3) @(posedge mclk);
    chk({16'h0, tx_period}, {16'h0, exp});
    fm_u.close_meas(feed);
  endtask
  // Verdict and end of run
  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Cuts a hang short
  initial begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    $display("Error at %0t: watchdog expired", $time);
    stop_test();
  end

  // Main sequence
  initial begin
    nrst = 1'b0;
    cen = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    mismatches = 0;
    n_tests = 0;
    repeat (20) @(posedge mclk);
    nrst <= 1'b1;
    chk({30'h0, cfg.magnitude_log_step}, 32'h1);
    rdchk(echo_cfg_pkg::OFS_GAIN, 32'h0);
    rdchk(echo_cfg_pkg::OFS_LOG, 32'h1000);
    // User store, top word holds 24 bits
    for (int i = 0; i < 4; i++) apb(1'b1, echo_cfg_pkg::OFS_USER0 + 8'(4 * i), 32'ha5c3_f0e1 ^ i);
    for (int i = 0; i < 3; i++) rdchk(echo_cfg_pkg::OFS_USER0 + 8'(4 * i), 32'ha5c3_f0e1 ^ i);
    rdchk(8'h2c, 32'h00c3_f0e2);
    // Unmapped place is refused
    apb(1'b1, 8'h1c, 32'hffff_ffff);
    chk({31'h0, err}, 32'h1);
    rdchk(8'h1c, 32'h0);
    // Background suppression on, then off
    apb(1'b1, echo_cfg_pkg::OFS_MEAS, 32'h2);
    fm_u.send_echo(16'd99, 16'd100);
    @(posedge mclk);
    chk({15'h0, echo_out}, {15'h0, 1'b1, 16'd0});
    fm_u.send_echo(16'd100, 16'd100);
    @(posedge mclk);
    chk({15'h0, echo_out}, {15'h0, 1'b1, 16'd100});
    apb(1'b1, echo_cfg_pkg::OFS_MEAS, 32'h0);
    fm_u.send_echo(16'd99, 16'd100);
    @(posedge mclk);
    chk({15'h0, echo_out}, {15'h0, 1'b1, 16'd99});
    // Offset set, then results above, at and below it
    apb(1'b1, echo_cfg_pkg::OFS_MEAS, 32'h0500);
    fm_u.send_tof(16'd20);
    @(posedge mclk);
    chk({15'h0, flight_time_valid, flight_time}, {15'h0, 1'b1, 16'd15});
    fm_u.send_tof(16'd5);
    @(posedge mclk);
    chk({15'h0, flight_time_valid, flight_time}, {15'h0, 1'b1, 16'd0});
    fm_u.send_tof(16'd4);
    @(posedge mclk);
    chk({15'h0, flight_time_valid, flight_time}, {15'h0, 1'b1, 16'd0});
    // Clock enable low freezes the result path
    @(posedge mclk);
    cen <= 1'b0;
    fm_u.send_tof(16'd30);
    @(posedge mclk);
    chk({15'h0, flight_time_valid, flight_time}, 32'h0);
    cen <= 1'b1;
    // Manual periods
    apb(1'b1, echo_cfg_pkg::OFS_TONE, 32'h0456_0123);
    rdchk(echo_cfg_pkg::OFS_TONE, 32'h0456_0123);
    fm_u.open_meas(1'b0);
    repeat (3) @(posedge mclk);
    chk({rx_period, tx_period}, 32'h0456_0123);
    fm_u.close_meas(16'd900);
    // Automatic period: first shot, then each tolerance band at its edges
    apb(1'b1, echo_cfg_pkg::OFS_MEAS, {P1, 16'h0001});
    meas_tx(P1, P1);
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, echo_cfg_pkg::OFS_RING, {14'h0, 2'(i / 2), 16'h0});
      meas_tx(P1 + dev[i], (i % 2 == 0) ? P1 : P1 + dev[i - 1]);
      meas_tx(P1 + dev[i], (i % 2 == 0) ? P1 + dev[i] : P1);
    end
    meas_tx(P1 + 16'd124, P1);
    // Indirect reception stays on the programmed period
    fm_u.open_meas(1'b1);
    repeat (3) @(posedge mclk);
    chk({16'h0, rx_period}, {16'h0, P1});
    fm_u.close_meas(P1 + 16'd124);
    // New programmed period re-arms the first shot
    apb(1'b1, echo_cfg_pkg::OFS_MEAS, {16'd1100, 16'h0001});
    meas_tx(16'd1124, 16'd1100);
    meas_tx(16'd1124, 16'd1124);
    // Timed measurement: gain start 1, watch 2, log start 1 step code 2
    apb(1'b1, echo_cfg_pkg::OFS_GAIN, 32'h1);
    apb(1'b1, echo_cfg_pkg::OFS_RING, 32'h2);
    apb(1'b1, echo_cfg_pkg::OFS_LOG, 32'h2001);
    fm_u.open_meas(1'b0);
    cnt = 0;
    for (int k = 1; k <= 2100; k++) begin
      @(posedge mclk);
      if (log_strobe === 1'b1) cnt++;
      if (k == 500) chk({31'h0, ringdown_watch}, 32'h1);
      if (k == 530) chk({31'h0, ringdown_watch}, 32'h0);
      if (k == 2040) chk({31'h0, gain_ramp_on}, 32'h0);
      if (k == 2070) chk({31'h0, gain_ramp_on}, 32'h1);
    end
    chk(32'(cnt), 32'h2);
    fm_u.close_meas(P1);
    stop_test();
  end
endmodule
`default_nettype wire
